// >>> hdl/dmas_core.sv
// Multiply-accumulate-saturate datapath with its AXI4-Lite control and status registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module dmas_core
(
   input wire logic ref_clk,
   input wire logic rst_n,
   // Operation request from the instruction execution logic
   input wire logic op_valid,
   input wire dmas_pkg::dmas_req_t op_req,
   // MCU multiply result
   output logic [31:0] mcu_result_q,
   output logic mcu_valid_q,
   // Accumulator contents for write-back logic
   output logic [39:0] first_acc_q,
   output logic [39:0] second_acc_q,
   // Status and trap request
   output logic either_guard_ovf,
   output logic either_clipped,
   output logic arith_trap_q,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Configuration and trap enable registers
   logic [7:0] cfg_q;
   logic [2:0] trap_en_q;
   // Status flags
   logic first_acc_guard_ovf_q;
   logic second_acc_guard_ovf_q;
   logic first_acc_clipped_q;
   logic second_acc_clipped_q;
   // Decoded configuration fields
   logic [1:0] per_acc_clip_enable;
   logic clip_width_select;
   logic first_guard_trap_en;
   logic second_guard_trap_en;
   logic sign_loss_trap_en;
   // Datapath signals
   logic [39:0] product;
   logic [31:0] mcu_result;
   logic [39:0] shifted;
   logic [39:0] operand;
   logic [39:0] target_acc;
   logic zero_acc;
   logic subtract;
   logic uses_adder;
   logic sel_clip_en;
   dmas_pkg::dmas_sum_t sum;
   logic upd_first;
   logic upd_second;
   // Bus write path state
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] clip_clear;
   logic trap_d;

   // Arithmetic shift by a signed amount: positive right, negative left, zero none
   function automatic logic [39:0] scale_shift(input logic [39:0] val, input logic signed [4:0] amt);
      logic [4:0] mag;
      mag = amt[4] ? 5'(-amt) : 5'(amt);
      if (amt[4])
      begin
         scale_shift = val << mag;
      end
      else
      begin
         scale_shift = 40'($signed(val) >>> mag);
      end
   endfunction

   // Register address match, used by both bus paths
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == dmas_pkg::CFG_OFS) || (addr == dmas_pkg::TRAP_OFS) ||
                  (addr == dmas_pkg::STAT_OFS) || (addr == dmas_pkg::ACC1_LO_OFS) ||
                  (addr == dmas_pkg::ACC1_HI_OFS) || (addr == dmas_pkg::ACC2_LO_OFS) ||
                  (addr == dmas_pkg::ACC2_HI_OFS);
   endfunction

   // Field decode
   // Clip enables and width from configuration
   assign per_acc_clip_enable = {cfg_q[dmas_pkg::CFG_CLIP_EN1_BIT], cfg_q[dmas_pkg::CFG_CLIP_EN2_BIT]};
   assign clip_width_select = cfg_q[dmas_pkg::CFG_CLIP_W_BIT];
   assign first_guard_trap_en = trap_en_q[dmas_pkg::TRAP_GUARD1_BIT];
   assign second_guard_trap_en = trap_en_q[dmas_pkg::TRAP_GUARD2_BIT];
   assign sign_loss_trap_en = trap_en_q[dmas_pkg::TRAP_SIGN_BIT];

   // Shared multiplier
   dmas_mult u_mult
   (
      .opa(op_req.opa),
      .opb(op_req.opb),
      .opa_signed(op_req.opa_signed),
      .opb_signed(op_req.opb_signed),
      .frac(op_req.frac),
      .byte_mode(op_req.byte_mode),
      .acc_product(product),
      .mcu_result(mcu_result)
   );

   // Bus data placed at bits 31:16, then shifted
   assign shifted = scale_shift({{8{op_req.data[15]}}, op_req.data, 16'h0000}, op_req.shift);

   // Operand and adder control per operation
   always_comb
   begin
      operand = product;
      zero_acc = 1'b0;
      subtract = 1'b0;
      uses_adder = op_valid;
      case (op_req.op)
         dmas_pkg::DMAS_OP_MAC:
         begin
            operand = product;
         end
         dmas_pkg::DMAS_OP_MSC:
         begin
            subtract = 1'b1;
         end
         // Zero accumulator side to load product
         dmas_pkg::DMAS_OP_MPY:
         begin
            zero_acc = 1'b1;
         end
         dmas_pkg::DMAS_OP_ADD:
         begin
            operand = shifted;
         end
         dmas_pkg::DMAS_OP_LOAD:
         begin
            operand = shifted;
            zero_acc = 1'b1;
         end
         // Clearing passes zero plus zero through the adder
         dmas_pkg::DMAS_OP_CLEAR:
         begin
            operand = 40'h00_0000_0000;
            zero_acc = 1'b1;
         end
         // The MCU multiply leaves the accumulators untouched
         dmas_pkg::DMAS_OP_MCU_MUL:
         begin
            uses_adder = 1'b0;
         end
         default:
         begin
            uses_adder = 1'b0;
         end
      endcase
   end

   assign target_acc = op_req.acc_sel ? second_acc_q : first_acc_q;
   assign sel_clip_en = op_req.acc_sel ? per_acc_clip_enable[0] : per_acc_clip_enable[1];

   // Adder, overflow detection and saturation
   dmas_addsat u_addsat
   (
      .acc_in(target_acc),
      .operand(operand),
      .zero_acc(zero_acc),
      .subtract(subtract),
      .clip_en(sel_clip_en),
      .clip_w40(clip_width_select),
      .sum(sum)
   );

   assign upd_first = uses_adder && !op_req.acc_sel;
   assign upd_second = uses_adder && op_req.acc_sel;

   // Accumulator update
   // Accumulators reset to zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_acc_q <= dmas_pkg::ACC_RESET;
         second_acc_q <= dmas_pkg::ACC_RESET;
      end
      else
      begin
         // Result back into the source accumulator
         if (upd_first)
         begin
            first_acc_q <= sum.value;
         end
         if (upd_second)
         begin
            second_acc_q <= sum.value;
         end
      end
   end

   // MCU multiply result, one-cycle valid pulse
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mcu_result_q <= 32'h0000_0000;
         mcu_valid_q <= 1'b0;
      end
      else
      begin
         mcu_valid_q <= op_valid && (op_req.op == dmas_pkg::DMAS_OP_MCU_MUL);
         // Product written only for the MCU multiply
         if (op_valid && (op_req.op == dmas_pkg::DMAS_OP_MCU_MUL))
         begin
            mcu_result_q <= mcu_result;
         end
      end
   end

   // Guard overflow flags follow the latest pass on their accumulator
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_acc_guard_ovf_q <= 1'b0;
         second_acc_guard_ovf_q <= 1'b0;
      end
      else
      begin
         if (upd_first)
         begin
            first_acc_guard_ovf_q <= sum.guard_ovf;
         end
         if (upd_second)
         begin
            second_acc_guard_ovf_q <= sum.guard_ovf;
         end
      end
   end

   // Write-one-to-clear mask for the clipped flags
   assign clip_clear = (wr_fire && (aw_addr_q == dmas_pkg::STAT_OFS) && w_strb_q[0]) ? w_data_q : 32'h0000_0000;

   // Sticky clipped flags; a new hit in the clearing cycle wins over the clear
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_acc_clipped_q <= 1'b0;
         second_acc_clipped_q <= 1'b0;
      end
      else
      begin
         first_acc_clipped_q <= (upd_first && sum.clip_hit) ||
                                (first_acc_clipped_q && !clip_clear[dmas_pkg::ST_CLIP1_BIT]);
         second_acc_clipped_q <= (upd_second && sum.clip_hit) ||
                                 (second_acc_clipped_q && !clip_clear[dmas_pkg::ST_CLIP2_BIT]);
      end
   end

   assign either_guard_ovf = first_acc_guard_ovf_q || second_acc_guard_ovf_q;
   assign either_clipped = first_acc_clipped_q || second_acc_clipped_q;

   // Trap request from the current flags and enables
   always_comb
   begin
      trap_d = 1'b0;
      if ((first_acc_guard_ovf_q && first_guard_trap_en) || (second_acc_guard_ovf_q && second_guard_trap_en))
      begin
         trap_d = 1'b1;
      end
      if (sign_loss_trap_en && ((first_acc_clipped_q && !per_acc_clip_enable[1]) ||
                                (second_acc_clipped_q && !per_acc_clip_enable[0])))
      begin
         trap_d = 1'b1;
      end
   end

   // Registered trap level, one cycle behind the flags
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arith_trap_q <= 1'b0;
      end
      else
      begin
         arith_trap_q <= trap_d;
      end
   end

   // Write address and data are captured independently, in either order
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_hit = is_mapped(aw_addr_q);

   // Write channel capture
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
         begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
         begin
            w_held_q <= 1'b0;
         end
      end
   end

   // Write response, held until the master takes it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dmas_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? dmas_pkg::RESP_OKAY : dmas_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software writable control registers; only byte lane 0 carries live bits
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= dmas_pkg::CFG_RESET;
         trap_en_q <= dmas_pkg::TRAP_RESET;
      end
      else if (wr_fire && w_strb_q[0])
      begin
         if (aw_addr_q == dmas_pkg::CFG_OFS)
         begin
            cfg_q <= w_data_q[7:0] & 8'hD0;
         end
         if (aw_addr_q == dmas_pkg::TRAP_OFS)
         begin
            trap_en_q <= w_data_q[2:0];
         end
      end
   end

   // Read path: one outstanding read, data held until taken
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dmas_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? dmas_pkg::RESP_OKAY : dmas_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            dmas_pkg::CFG_OFS: s_axi_rdata <= {24'h00_0000, cfg_q};
            dmas_pkg::TRAP_OFS: s_axi_rdata <= {29'h0000_0000, trap_en_q};
            dmas_pkg::STAT_OFS: s_axi_rdata <= {25'h000_0000, arith_trap_q, either_clipped, either_guard_ovf,
                                                second_acc_clipped_q, first_acc_clipped_q,
                                                second_acc_guard_ovf_q, first_acc_guard_ovf_q};
            dmas_pkg::ACC1_LO_OFS: s_axi_rdata <= first_acc_q[31:0];
            dmas_pkg::ACC1_HI_OFS: s_axi_rdata <= {24'h00_0000, first_acc_q[39:32]};
            dmas_pkg::ACC2_LO_OFS: s_axi_rdata <= second_acc_q[31:0];
            dmas_pkg::ACC2_HI_OFS: s_axi_rdata <= {24'h00_0000, second_acc_q[39:32]};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> hdl/dmas_pkg.sv
// Shared constants, types and register map of the multiply-accumulate-saturate datapath
package dmas_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] TRAP_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] ACC1_LO_OFS = 8'h0C;
   localparam logic [7:0] ACC1_HI_OFS = 8'h10;
   localparam logic [7:0] ACC2_LO_OFS = 8'h14;
   localparam logic [7:0] ACC2_HI_OFS = 8'h18;
   // Configuration register fields
   localparam int CFG_CLIP_EN1_BIT = 7;
   localparam int CFG_CLIP_EN2_BIT = 6;
   localparam int CFG_CLIP_W_BIT = 4;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Trap control register fields
   localparam int TRAP_GUARD1_BIT = 0;
   localparam int TRAP_GUARD2_BIT = 1;
   localparam int TRAP_SIGN_BIT = 2;
   localparam logic [2:0] TRAP_RESET = 3'h0;
   // Status register fields
   localparam int ST_GUARD1_BIT = 0;
   localparam int ST_GUARD2_BIT = 1;
   localparam int ST_CLIP1_BIT = 2;
   localparam int ST_CLIP2_BIT = 3;
   localparam int ST_ANY_GUARD_BIT = 4;
   localparam int ST_ANY_CLIP_BIT = 5;
   localparam int ST_TRAP_BIT = 6;
   // Accumulator reset and saturation limits
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
   localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
   localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
   localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operations issued by the instruction execution logic
   typedef enum logic [2:0] {
      DMAS_OP_MAC,
      DMAS_OP_MSC,
      DMAS_OP_MPY,
      DMAS_OP_ADD,
      DMAS_OP_LOAD,
      DMAS_OP_MCU_MUL,
      DMAS_OP_CLEAR
   } dmas_op_t;

   // One operation request with its operands
   typedef struct packed {
      dmas_op_t op;
      logic acc_sel;
      logic opa_signed;
      logic opb_signed;
      logic frac;
      logic byte_mode;
      logic signed [4:0] shift;
      logic [15:0] opa;
      logic [15:0] opb;
      logic [15:0] data;
   } dmas_req_t;

   // Adder result with its overflow indications
   typedef struct packed {
      logic [39:0] value;
      logic guard_ovf;
      logic clip_hit;
   } dmas_sum_t;
endpackage

// >>> hdl/dmas_mult.sv
// Shared 17x17 multiplier with fractional or integer scaling
`timescale 1ns/100ps
module dmas_mult
(
   input wire logic [15:0] opa,
   input wire logic [15:0] opb,
   input wire logic opa_signed,
   input wire logic opb_signed,
   input wire logic frac,
   input wire logic byte_mode,
   output logic [39:0] acc_product,
   output logic [31:0] mcu_result
);
   // Operands widened to 17 bits
   logic signed [16:0] ext_a;
   logic signed [16:0] ext_b;
   // Full signed product of two 17-bit values
   logic signed [33:0] full;
   // Scaled 33-bit product
   logic [32:0] scaled;

   // Zero or sign extension
   // Byte operands are widened the same way from bit 7 so one multiplier serves both sizes
   always_comb
   begin
      if (byte_mode)
      begin
         ext_a = {{9{opa_signed & opa[7]}}, opa[7:0]};
         ext_b = {{9{opb_signed & opb[7]}}, opb[7:0]};
      end
      else
      begin
         ext_a = {opa_signed & opa[15], opa};
         ext_b = {opb_signed & opb[15], opb};
      end
   end

   assign full = ext_a * ext_b;

   // Fractional shift gives 1.31
   // The left shift drops the duplicated sign bit of a Q15 by Q15 product
   assign scaled = frac ? {full[31:0], 1'b0} : full[32:0];

   assign acc_product = {{7{scaled[32]}}, scaled};

   // Byte gives 16, word gives 32 bits
   assign mcu_result = byte_mode ? {16'h0000, full[15:0]} : full[31:0];
endmodule

// >>> hdl/dmas_addsat.sv
// 40-bit adder/subtracter with overflow detection and saturation
`timescale 1ns/100ps
module dmas_addsat
(
   input wire logic [39:0] acc_in,
   input wire logic [39:0] operand,
   input wire logic zero_acc,
   input wire logic subtract,
   input wire logic clip_en,
   input wire logic clip_w40,
   output dmas_pkg::dmas_sum_t sum
);
   // Adder inputs after zero and complement selection
   logic [39:0] in_a;
   logic [39:0] in_b;
   logic carry_in;
   logic [39:0] raw;
   // Overflow out of bit 39 and out of the 1.31 range
   logic ovf39;
   logic ovf31;
   // Sign the result would have had with infinite width
   logic true_neg;

   // Zero input and true or complement
   assign in_a = zero_acc ? 40'h00_0000_0000 : acc_in;
   assign in_b = subtract ? ~operand : operand;
   // Carry in low on add, high on subtract
   // Borrow is active low, so no borrow means a carry of one into the complement
   assign carry_in = subtract;
   assign raw = in_a + in_b + {39'h0, carry_in};

   // Sign lost out of bit 39
   assign ovf39 = (in_a[39] == in_b[39]) && (raw[39] != in_a[39]);
   assign true_neg = raw[39] ^ ovf39;
   // Bits 39:31 must all agree for a value that fits 1.31
   assign ovf31 = ovf39 || !((&raw[39:31]) || !(|raw[39:31]));

   always_comb
   begin
      sum.value = raw;
      // Guard flag never set in 32-bit mode
      sum.guard_ovf = !((&raw[39:32]) || !(|raw[39:32])) && !(clip_en && !clip_w40);
      // Without saturation, bit 39 overflow only
      sum.clip_hit = ovf39;
      if (clip_en && clip_w40)
      begin
         sum.clip_hit = ovf39;
         if (ovf39)
         begin
            sum.value = true_neg ? dmas_pkg::SAT40_NEG : dmas_pkg::SAT40_POS;
         end
      end
      else if (clip_en)
      begin
         sum.clip_hit = ovf31;
         if (ovf31)
         begin
            sum.value = true_neg ? dmas_pkg::SAT32_NEG : dmas_pkg::SAT32_POS;
         end
      end
   end
endmodule

// >>> test/dmas_core_asserts.sv
// Port checks on the multiply-accumulate datapath
`timescale 1ns/100ps
module dmas_core_asserts
(
   input logic ref_clk,
   input logic rst_n,
   input logic op_valid,
   input dmas_pkg::dmas_req_t op_req,
   input logic mcu_valid_q,
   input logic [39:0] first_acc_q,
   input logic [39:0] second_acc_q,
   input logic either_clipped,
   input logic either_guard_ovf,
   input logic arith_trap_q,
   input logic s_axi_wvalid,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // MCU multiply taken this edge
   wire mul = op_valid && op_req.op == dmas_pkg::DMAS_OP_MCU_MUL;
   // Clear aimed at the first accumulator
   wire clr = op_valid && !op_req.acc_sel && op_req.op == dmas_pkg::DMAS_OP_CLEAR;
   property p_mul; mul |=> mcu_valid_q; endproperty
   a_mul: assert property (p_mul) else $error("mcu result not flagged");
   property p_nomul; !mul |=> !mcu_valid_q; endproperty
   a_nomul: assert property (p_nomul) else $error("stray mcu valid");
   property p_mkeep; mul |=> $stable(first_acc_q) && $stable(second_acc_q); endproperty
   a_mkeep: assert property (p_mkeep) else $error("mcu op moved an accumulator");
   property p_idle; !op_valid |=> $stable(first_acc_q) && $stable(second_acc_q); endproperty
   a_idle: assert property (p_idle) else $error("accumulator moved while idle");
   property p_gidle; !op_valid |=> $stable(either_guard_ovf); endproperty
   a_gidle: assert property (p_gidle) else $error("guard flag moved while idle");
   property p_clr; clr |=> first_acc_q == 40'h00_0000_0000; endproperty
   a_clr: assert property (p_clr) else $error("clear left data");
   property p_trap; $rose(arith_trap_q) |-> $past(either_guard_ovf || either_clipped); endproperty
   a_trap: assert property (p_trap) else $error("trap without cause");
   // Write data may clear the flag one edge late, so look back too
   property p_stick; either_clipped && !s_axi_wvalid && !$past(s_axi_wvalid) && !s_axi_bvalid |=> either_clipped;
   endproperty
   a_stick: assert property (p_stick) else $error("clipped flag dropped");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   c_trap: cover property (arith_trap_q);
   c_clip: cover property ($rose(either_clipped));
   c_mul: cover property (mul);
endmodule
bind dmas_core dmas_core_asserts chk_u (.*);

// >>> test/dmas_exec_model.sv
// Instruction execution side: issues one operation at a time
`timescale 1ns/100ps
module dmas_exec_model
(
   input logic ref_clk,
   output logic op_valid,
   output dmas_pkg::dmas_req_t op_req
);
   // Idle before the first request
   initial
   begin
      op_valid = 1'b0;
      op_req = '0;
   end
   // Valid for exactly one cycle, so one operation each call
   task automatic issue(input dmas_pkg::dmas_req_t r);
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_req <= r;
      @(posedge ref_clk);
      op_valid <= 1'b0;
   endtask
endmodule

// >>> test/dmas_core_tb.sv
// Self-checking bench of the multiply-accumulate datapath
`timescale 1ns/100ps
module dmas_core_tb;
   localparam logic [39:0] SX [4] = '{dmas_pkg::SAT40_POS, dmas_pkg::SAT40_NEG, dmas_pkg::SAT32_POS,
      dmas_pkg::SAT32_NEG};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid;
   dmas_pkg::dmas_req_t op_req;
   logic [31:0] mcu_result_q;
   logic mcu_valid_q, either_guard_ovf, either_clipped, arith_trap_q;
   logic [39:0] first_acc_q, second_acc_q;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   int num_errors = 0;
   int cmp_count = 0;
   dmas_core dut_u (.*);
   dmas_exec_model mdl_u (.ref_clk(ref_clk), .op_valid(op_valid), .op_req(op_req));
   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Both write channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa;
      logic pw;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
         @(negedge ref_clk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         @(posedge ref_clk);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(negedge ref_clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(negedge ref_clk); while (!s_axi_arready);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge ref_clk); while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask
   // Request with data equal to operand a, first accumulator; f is frac, signed, byte
   function automatic dmas_pkg::dmas_req_t rq(dmas_pkg::dmas_op_t o, logic [15:0] a, logic [15:0] b,
      logic [2:0] f, logic signed [4:0] s);
      rq = '{o, 1'b0, f[1], f[1], f[2], f[0], s, a, b, a};
   endfunction
   task automatic op(input dmas_pkg::dmas_req_t r);
      mdl_u.issue(r);
      @(negedge ref_clk);
   endtask
   task automatic mcu(input logic [15:0] a, input logic [15:0] b, input logic [2:0] f, input logic [31:0] e);
      op(rq(dmas_pkg::DMAS_OP_MCU_MUL, a, b, f, 5'sd0));
      chk(40'(mcu_result_q), 40'(e));
      chk(40'(mcu_valid_q), 40'h1);
   endtask
   task automatic final_report();
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog for a hung handshake
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      num_errors++;
      final_report();
   end
   initial
   begin
      dmas_pkg::dmas_req_t r;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(dmas_pkg::STAT_OFS);
      chk(40'(rdat), 40'h0);
      op(rq(dmas_pkg::DMAS_OP_MAC, 16'h4000, 16'h4000, 3'h6, 5'sd0));
      chk(first_acc_q, 40'h00_2000_0000);
      op(rq(dmas_pkg::DMAS_OP_MSC, 16'h4000, 16'h4000, 3'h6, 5'sd0));
      chk(first_acc_q, 40'h0);
      op(rq(dmas_pkg::DMAS_OP_MPY, 16'hFFFF, 16'h0002, 3'h2, 5'sd0));
      chk(first_acc_q, 40'hFF_FFFF_FFFE);
      mcu(16'hFFFF, 16'h0002, 3'h2, 32'hFFFF_FFFE);
      mcu(16'hFFFF, 16'h0002, 3'h0, 32'h0001_FFFE);
      mcu(16'h00FF, 16'h00FF, 3'h1, 32'h0000_FE01);
      op(rq(dmas_pkg::DMAS_OP_LOAD, 16'h7FFF, 16'h0, 3'h0, -5'sd8));
      chk(first_acc_q, 40'h7F_FF00_0000);
      chk(40'(either_guard_ovf), 40'h1);
      wr(dmas_pkg::TRAP_OFS, 32'h1);
      @(negedge ref_clk);
      chk(40'(arith_trap_q), 40'h1);
      wr(dmas_pkg::TRAP_OFS, 32'h4);
      op(rq(dmas_pkg::DMAS_OP_ADD, 16'h7FFF, 16'h0, 3'h0, -5'sd8));
      @(negedge ref_clk);
      chk(first_acc_q, 40'hFF_FE00_0000);
      chk(40'(either_guard_ovf), 40'h0);
      chk(40'(arith_trap_q), 40'h1);
      rd(dmas_pkg::STAT_OFS);
      chk(40'(rdat), 40'h64);
      op(rq(dmas_pkg::DMAS_OP_LOAD, 16'h0, 16'h0, 3'h0, 5'sd0));
      chk(40'(either_clipped), 40'h1);
      wr(dmas_pkg::STAT_OFS, 32'h4);
      chk(40'(either_clipped), 40'h0);
      for (int i = 0; i < 4; i++)
      begin
         wr(dmas_pkg::CFG_OFS, i < 2 ? 32'h90 : 32'h80);
         op(rq(dmas_pkg::DMAS_OP_LOAD, i[0] ? 16'h8000 : 16'h7FFF, 16'h0, 3'h0, -5'sd8));
         op(rq(dmas_pkg::DMAS_OP_ADD, i[0] ? 16'h8000 : 16'h7FFF, 16'h0, 3'h0, -5'sd8));
         chk(first_acc_q, SX[i]);
         chk(40'(either_clipped), 40'h1);
         chk(40'(either_guard_ovf), 40'h0);
         wr(dmas_pkg::STAT_OFS, 32'h4);
      end
      rd(dmas_pkg::ACC1_HI_OFS);
      chk(40'(rdat), 40'hFF);
      rd(8'h1C);
      chk(40'({rsp, rdat}), 40'({dmas_pkg::RESP_SLVERR, 32'h0}));
      wr(dmas_pkg::CFG_OFS, 32'hFF);
      rd(dmas_pkg::CFG_OFS);
      chk(40'(rdat), 40'hD0);
      op(rq(dmas_pkg::DMAS_OP_CLEAR, 16'h0, 16'h0, 3'h0, 5'sd0));
      chk(first_acc_q, 40'h0);
      // Second accumulator takes a load, the first stays put
      r = rq(dmas_pkg::DMAS_OP_LOAD, 16'h7FFF, 16'h0, 3'h0, -5'sd8);
      r.acc_sel = 1'b1;
      op(r);
      chk(second_acc_q, 40'h7F_FF00_0000);
      chk(first_acc_q, 40'h0);
      chk(40'(either_guard_ovf), 40'h1);
      // Only the second guard enable is on, so a trap proves its decode
      wr(dmas_pkg::TRAP_OFS, 32'h2);
      chk(40'(rsp), 40'(dmas_pkg::RESP_OKAY));
      @(negedge ref_clk);
      chk(40'(arith_trap_q), 40'h1);
      final_report();
   end
endmodule
